// [logic/cpu_flags_pkg.sv]
// constants, types and reset values of the cpu condition-flags unit
// Function
// [RULE1] flags are eight bits: V7 H4 I3 N2 Z1 C0, bits 6 and 5 read one
// [RULE2] any reset sets the mask; afterwards only clear-mask, wait, stop or a return from interrupt clears it
// [RULE3] overflow flag marks signed overflow; signed branches test it
// [RULE4] nibble carry follows carry from bit 3 into bit 4 on adds
// [RULE5] decimal adjust picks its correction from nibble carry and carry
// [RULE6] mask set blocks maskable interrupts; mask clear lets them in
// [RULE7] interrupt entry sets the mask after stacking, before vector fetch; the code raises it in the vector-fetch cycle
// [RULE8] interrupt entry never stacks the index high byte
// [RULE9] with the mask clear, the highest-priority pending request goes first
// [RULE10] return from interrupt restores flags and mask from the stack
// [RULE11] sign flag copies bit 7 of an alu result
// [RULE12] zero flag is set for a zero result, cleared otherwise
// [RULE13] carry takes add carry, subtract borrow, shift, rotate, bit test
// [RULE14] wait clears mask, stops cpu clock; irq exit keeps mask clear
// [RULE15] stop clears mask, stops clock; exit restarts after stabilization
// [RULE16] opcode a7 adds signed immediate to stack pointer in 2 cycles
// [RULE17] opcode af adds signed immediate to index register in 2 cycles
// [RULE18] opcode 24 branches to pc+2+offset when carry clear, 3 cycles
// [RULE19] writes to flag bits 6 and 5 are ignored
package cpu_flags_pkg;

  localparam int V_BIT = 7;
  localparam int H_BIT = 4;
  localparam int I_BIT = 3;
  localparam int N_BIT = 2;
  localparam int Z_BIT = 1;
  localparam int C_BIT = 0;
  localparam logic [7:0] ONES_MASK = 8'h60;
  localparam logic [7:0] FLAGS_RESET = 8'h68;
  localparam logic [15:0] SP_RESET = 16'h00ff;
  localparam logic [15:0] HX_RESET = 16'h0000;

  localparam logic [3:0] FLAGS_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h1;

  localparam logic [7:0] SP_IMM_ADD_OPCODE = 8'ha7;
  localparam logic [7:0] IX_IMM_ADD_OPCODE = 8'haf;
  localparam logic [7:0] NO_CARRY_BRANCH_OPCODE = 8'h24;
  localparam logic [15:0] IMM_ADD_CYCLES = 16'h0002;
  localparam logic [15:0] BRANCH_CYCLES = 16'h0003;
  localparam logic [15:0] BRANCH_PC_STEP = 16'h0002;
  localparam logic [15:0] PUSH_BYTES = 16'h0005;

  localparam logic [7:0] DAA_LOW_FIX = 8'h06;
  localparam logic [7:0] DAA_HIGH_FIX = 8'h60;
  localparam logic [3:0] NIBBLE_MAX = 4'h9;
  localparam logic [7:0] BCD_MAX = 8'h99;

  typedef enum logic [4:0] {
    NO_OP, ADD_OP, ADC_OP, SUB_OP, SBC_OP, LOGIC_AND_OP, SHIFT_LEFT_OP,
    SHIFT_RIGHT_OP, ROTATE_LEFT_OP, DECIMAL_ADJUST_OP, CLEAR_MASK_OP,
    SET_MASK_OP, RETURN_FROM_INTERRUPT_OP, WAIT_OP, STOP_OP,
    SIGNED_BRANCH_OP, BIT_TEST_BRANCH_OP, OPCODE_OP
  } op_kind_t;

  typedef enum logic [1:0] {
    BRANCH_SIGNED_GREATER_OP, BRANCH_SIGNED_GREATER_EQUAL_OP,
    BRANCH_SIGNED_LESS_EQUAL_OP, BRANCH_SIGNED_LESS_OP
  } branch_cond_t;

  typedef enum logic [2:0] {
    ST_RUN, ST_EXEC, ST_PUSH, ST_VECTOR, ST_WAIT, ST_STOP, ST_STABILIZE
  } run_st_t;

  typedef struct packed {
    op_kind_t op;
    logic [7:0] opcode;
    logic [7:0] a;
    logic [7:0] b;
    branch_cond_t cond;
    logic [15:0] pc;
    logic [7:0] stacked_flags;
  } cmd_t;

  typedef struct packed {
    logic [7:0] value;
    logic [15:0] pc_next;
    logic taken;
    logic done;
  } res_t;

  typedef struct packed {
    run_st_t st;
    logic [7:0] flags;
    logic [15:0] sp;
    logic [15:0] hx;
    logic [15:0] cnt;
    logic [7:0] opcode;
    logic [15:0] pc;
    logic [7:0] offset;
    res_t res;
    logic nz_upd;
    logic push;
    logic [2:0] slot;
    logic vec;
    logic [3:0] vec_id;
    logic [7:0] rdata;
  } state_t;

  localparam state_t STATE_RESET = '{
    st: ST_RUN, flags: FLAGS_RESET, sp: SP_RESET, hx: HX_RESET,
    cnt: 16'h0000, opcode: 8'h00, pc: 16'h0000, offset: 8'h00,
    res: '0, nz_upd: 1'b0, push: 1'b0, slot: 3'h0, vec: 1'b0,
    vec_id: 4'h0, rdata: 8'h00
  };

endpackage

// [logic/cpu_condition_flags_unit.sv]
// condition flags, interrupt mask and low-power sequencing of the cpu core
`timescale 1ns/1ps
`default_nettype none
module cpu_condition_flags_unit import cpu_flags_pkg::*; #(
  parameter int NUM_IRQ = 8,
  parameter int OSC_STAB_CYCLES = 4096
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire cmd_t cmd,
  output logic cmd_ready,
  output res_t result,
  input wire logic [NUM_IRQ-1:0] irq_req,
  input wire logic ext_irq,
  output logic stack_push,
  output logic [2:0] stack_slot,
  output logic vector_fetch,
  output logic [3:0] vector_id,
  output logic cpu_clock_off,
  output logic [7:0] flags,
  output logic [15:0] stack_pointer,
  output logic [15:0] index_reg,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] sext8(input logic [7:0] v);
    return {{8{v[7]}}, v};
  endfunction

  // returns {v, h, c, result}; subtract runs as a + ~b + ~cin, carry inverted
  function automatic logic [10:0] arith(input logic [7:0] a,
                                        input logic [7:0] b,
                                        input logic cin,
                                        input logic sub);
    logic [7:0] bb;
    logic ci;
    logic [8:0] full;
    logic [4:0] half;
    logic v;
    bb = sub ? ~b : b;
    ci = sub ? ~cin : cin;
    full = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
    half = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
    v = (a[7] == bb[7]) && (full[7] != a[7]);
    return {v, half[4], sub ? ~full[8] : full[8], full[7:0]};
  endfunction

  function automatic logic [3:0] first_req(input logic [NUM_IRQ-1:0] req);
    logic [3:0] id;
    id = 4'h0;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (req[i]) begin
        id = 4'(i);
      end
    end
    return id;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  state_t s_q, s_d;
  logic take_irq;
  logic cmd_fire;
  logic [10:0] alu;
  logic sub_op;
  logic cin;
  logic n_x_v;
  logic cond_ok;
  logic [7:0] shift_r;
  logic shift_c;
  logic [7:0] fix;

  // interrupts only between instructions, never while the mask is set
  assign take_irq = (s_q.st == ST_RUN) && !s_q.flags[I_BIT]
                    && (|irq_req); // RULE6
  assign cmd_ready = (s_q.st == ST_RUN) && !take_irq;
  assign cmd_fire = cmd_valid && cmd_ready;

  assign sub_op = (cmd.op == SUB_OP) || (cmd.op == SBC_OP);
  assign cin = ((cmd.op == ADC_OP) || (cmd.op == SBC_OP))
               && s_q.flags[C_BIT];
  assign alu = arith(cmd.a, cmd.b, cin, sub_op);
  assign n_x_v = s_q.flags[N_BIT] ^ s_q.flags[V_BIT]; // RULE3

  always_comb begin
    case (cmd.cond)
      BRANCH_SIGNED_GREATER_OP: cond_ok = !(s_q.flags[Z_BIT] | n_x_v);
      BRANCH_SIGNED_GREATER_EQUAL_OP: cond_ok = !n_x_v;
      BRANCH_SIGNED_LESS_EQUAL_OP: cond_ok = s_q.flags[Z_BIT] | n_x_v;
      BRANCH_SIGNED_LESS_OP: cond_ok = n_x_v;
      default: cond_ok = 1'b0;
    endcase
  end

  always_comb begin
    case (cmd.op)
      SHIFT_LEFT_OP: begin
        shift_r = {cmd.a[6:0], 1'b0};
        shift_c = cmd.a[7];
      end
      SHIFT_RIGHT_OP: begin
        shift_r = {cmd.a[7], cmd.a[7:1]};
        shift_c = cmd.a[0];
      end
      default: begin
        shift_r = {cmd.a[6:0], s_q.flags[C_BIT]};
        shift_c = cmd.a[7];
      end
    endcase
  end

  // decimal correction steered by nibble carry and carry
  always_comb begin
    fix = 8'h00;
    if (s_q.flags[H_BIT] || (cmd.a[3:0] > NIBBLE_MAX)) begin // RULE5
      fix = fix | DAA_LOW_FIX;
    end
    if (s_q.flags[C_BIT] || (cmd.a > BCD_MAX)) begin // RULE5
      fix = fix | DAA_HIGH_FIX;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d = s_q;
    s_d.res.done = 1'b0;
    s_d.push = 1'b0;
    s_d.vec = 1'b0;
    s_d.nz_upd = 1'b0;
    s_d.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        FLAGS_OFS: s_d.rdata = s_q.flags;
        STATUS_OFS: s_d.rdata = {s_q.vec_id, 1'b0,
                                 s_q.st == ST_STABILIZE,
                                 s_q.st != ST_RUN, cpu_clock_off};
        default: s_d.rdata = 8'h00;
      endcase
    end
    // software may raise the mask but cannot drop it
    if (reg_wr && (reg_addr == FLAGS_OFS)) begin
      s_d.flags = (reg_wdata & ~ONES_MASK) | ONES_MASK; // RULE19
      s_d.flags[I_BIT] = s_q.flags[I_BIT] | reg_wdata[I_BIT]; // RULE2
    end
    case (s_q.st)
      ST_RUN: begin
        if (take_irq) begin
          // first byte stacked now; index high byte is never in the frame
          s_d.st = ST_PUSH;
          s_d.push = 1'b1;
          s_d.slot = 3'h0; // RULE8
          s_d.sp = s_q.sp - 16'h0001;
          s_d.cnt = PUSH_BYTES - 16'h0001;
          s_d.vec_id = first_req(irq_req); // RULE9
        end else if (cmd_fire) begin
          s_d.res.done = 1'b1;
          s_d.res.taken = 1'b0;
          case (cmd.op)
            ADD_OP, ADC_OP, SUB_OP, SBC_OP: begin
              s_d.res.value = alu[7:0];
              s_d.flags[V_BIT] = alu[10]; // RULE3
              if (!sub_op) begin
                s_d.flags[H_BIT] = alu[9]; // RULE4
              end
              s_d.flags[C_BIT] = alu[8]; // RULE13
              s_d.flags[N_BIT] = alu[7]; // RULE11
              s_d.flags[Z_BIT] = alu[7:0] == 8'h00; // RULE12
              s_d.nz_upd = 1'b1;
            end
            LOGIC_AND_OP: begin
              s_d.res.value = cmd.a & cmd.b;
              s_d.flags[V_BIT] = 1'b0;
              s_d.flags[N_BIT] = cmd.a[7] & cmd.b[7]; // RULE11
              s_d.flags[Z_BIT] = (cmd.a & cmd.b) == 8'h00; // RULE12
              s_d.nz_upd = 1'b1;
            end
            SHIFT_LEFT_OP, SHIFT_RIGHT_OP, ROTATE_LEFT_OP: begin
              s_d.res.value = shift_r;
              s_d.flags[C_BIT] = shift_c; // RULE13
              s_d.flags[N_BIT] = shift_r[7]; // RULE11
              s_d.flags[Z_BIT] = shift_r == 8'h00; // RULE12
              s_d.flags[V_BIT] = shift_r[7] ^ shift_c; // RULE3
              s_d.nz_upd = 1'b1;
            end
            DECIMAL_ADJUST_OP: begin
              s_d.res.value = cmd.a + fix; // RULE5
              s_d.flags[C_BIT] = fix[6]; // RULE13
              s_d.flags[N_BIT] = s_d.res.value[7]; // RULE11
              s_d.flags[Z_BIT] = s_d.res.value == 8'h00; // RULE12
              s_d.nz_upd = 1'b1;
            end
            CLEAR_MASK_OP: s_d.flags[I_BIT] = 1'b0; // RULE2
            SET_MASK_OP: s_d.flags[I_BIT] = 1'b1;
            RETURN_FROM_INTERRUPT_OP: begin
              s_d.flags = cmd.stacked_flags | ONES_MASK; // RULE10 RULE1
              s_d.sp = s_q.sp + PUSH_BYTES;
            end
            WAIT_OP: begin
              s_d.flags[I_BIT] = 1'b0; // RULE14
              s_d.st = ST_WAIT;
            end
            STOP_OP: begin
              s_d.flags[I_BIT] = 1'b0; // RULE15
              s_d.st = ST_STOP;
            end
            SIGNED_BRANCH_OP: begin
              s_d.res.taken = cond_ok; // RULE3
              s_d.res.pc_next = cmd.pc + BRANCH_PC_STEP
                                + (cond_ok ? sext8(cmd.b) : 16'h0000);
            end
            BIT_TEST_BRANCH_OP: begin
              s_d.flags[C_BIT] = cmd.a[cmd.b[2:0]]; // RULE13
              s_d.res.taken = cmd.a[cmd.b[2:0]];
            end
            OPCODE_OP: begin
              s_d.opcode = cmd.opcode;
              s_d.pc = cmd.pc;
              s_d.offset = cmd.b;
              if ((cmd.opcode == SP_IMM_ADD_OPCODE)
                  || (cmd.opcode == IX_IMM_ADD_OPCODE)) begin
                s_d.res.done = 1'b0;
                s_d.st = ST_EXEC;
                s_d.cnt = IMM_ADD_CYCLES - 16'h0001; // RULE16 RULE17
              end else if (cmd.opcode == NO_CARRY_BRANCH_OPCODE) begin
                s_d.res.done = 1'b0;
                s_d.st = ST_EXEC;
                s_d.cnt = BRANCH_CYCLES - 16'h0001; // RULE18
              end
            end
            default: s_d.res.done = 1'b1;
          endcase
        end
      end
      ST_EXEC: begin
        s_d.cnt = s_q.cnt - 16'h0001;
        if (s_q.cnt == 16'h0001) begin
          s_d.st = ST_RUN;
          s_d.res.done = 1'b1;
          case (s_q.opcode)
            SP_IMM_ADD_OPCODE: s_d.sp = s_q.sp + sext8(s_q.offset); // RULE16
            IX_IMM_ADD_OPCODE: s_d.hx = s_q.hx + sext8(s_q.offset); // RULE17
            NO_CARRY_BRANCH_OPCODE: begin
              s_d.res.taken = !s_q.flags[C_BIT]; // RULE18
              s_d.res.pc_next = s_q.pc + BRANCH_PC_STEP
                + (s_q.flags[C_BIT] ? 16'h0000 : sext8(s_q.offset));
            end
            default: s_d.res.taken = 1'b0;
          endcase
        end
      end
      ST_PUSH: begin
        s_d.push = 1'b1;
        s_d.slot = 3'(PUSH_BYTES - s_q.cnt);
        s_d.sp = s_q.sp - 16'h0001;
        s_d.cnt = s_q.cnt - 16'h0001;
        if (s_q.cnt == 16'h0001) begin
          s_d.st = ST_VECTOR;
        end
      end
      ST_VECTOR: begin
        // mask rises with the fetch, one cycle after the last stack write
        s_d.flags[I_BIT] = 1'b1; // RULE7
        s_d.vec = 1'b1;
        s_d.st = ST_RUN;
      end
      ST_WAIT: begin
        if (|irq_req) begin
          s_d.st = ST_RUN; // RULE14
        end
      end
      ST_STOP: begin
        if (ext_irq) begin
          s_d.st = ST_STABILIZE;
          s_d.cnt = 16'(OSC_STAB_CYCLES); // RULE15
        end
      end
      ST_STABILIZE: begin
        s_d.cnt = s_q.cnt - 16'h0001;
        if (s_q.cnt <= 16'h0001) begin
          s_d.st = ST_RUN; // RULE15
        end
      end
      default: s_d.st = ST_RUN;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_q <= STATE_RESET; // RULE2
    end else begin
      s_q <= s_d;
    end
  end

  assign result = s_q.res;
  assign stack_push = s_q.push;
  assign stack_slot = s_q.slot;
  assign vector_fetch = s_q.vec;
  assign vector_id = s_q.vec_id;
  assign cpu_clock_off = (s_q.st == ST_WAIT) || (s_q.st == ST_STOP)
                         || (s_q.st == ST_STABILIZE); // RULE14 RULE15
  assign flags = s_q.flags;
  assign stack_pointer = s_q.sp;
  assign index_reg = s_q.hx;
  assign reg_rdata = s_q.rdata;

  ////////////////////////////////////////////////////////////////////////////
  logic mask_drop_ok;
  logic [8:0] add_sum;
  assign mask_drop_ok = cmd_fire && ((cmd.op == CLEAR_MASK_OP)
    || (cmd.op == WAIT_OP) || (cmd.op == STOP_OP)
    || ((cmd.op == RETURN_FROM_INTERRUPT_OP) && !cmd.stacked_flags[I_BIT]));
  assign add_sum = {1'b0, cmd.a} + {1'b0, cmd.b};

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  ones_bits_a: assert property (flags[6:5] == 2'b11) // RULE1
    else $error("flag bits 6 and 5 not one");
  mask_drop_a: assert property ($fell(flags[I_BIT]) |-> // RULE2
    $past(mask_drop_ok))
    else $error("mask cleared without a clearing op");
  add_flags_a: assert property (cmd_fire && cmd.op == ADD_OP |=> // RULE4
    flags[H_BIT] == $past(add_sum[4] ^ cmd.a[4] ^ cmd.b[4])
    && flags[C_BIT] == $past(add_sum[8]))
    else $error("add nibble carry or carry wrong");
  irq_blocked_a: assert property (flags[I_BIT] && s_q.st == ST_RUN |=> // RULE6
    !stack_push) else $error("interrupt taken while masked");
  entry_order_a: assert property (take_irq |=> stack_push[*5] // RULE7
    ##1 (vector_fetch && flags[I_BIT] && !stack_push))
    else $error("interrupt entry sequence wrong");
  entry_slots_a: assert property (stack_push |-> stack_slot < 3'h5) // RULE8
    else $error("stack slot beyond the five-byte frame");
  irq_priority_a: assert property (take_irq |=> // RULE9
    (|($past(irq_req) & (NUM_IRQ'(1) << vector_id)))
    && (($past(irq_req) << (NUM_IRQ - vector_id)) == '0))
    else $error("lower-priority request served first");
  result_nz_a: assert property (s_q.nz_upd |-> // RULE11
    flags[N_BIT] == result.value[7]
    && flags[Z_BIT] == (result.value == 8'h00))
    else $error("sign or zero flag does not match result");
  wait_entry_a: assert property (cmd_fire && cmd.op == WAIT_OP |=> // RULE14
    !flags[I_BIT] && cpu_clock_off)
    else $error("wait did not clear mask and stop clock");
  stop_exit_a: assert property (s_q.st == ST_STOP && ext_irq |=> // RULE15
    cpu_clock_off && !flags[I_BIT] && s_q.st == ST_STABILIZE)
    else $error("stop exit skipped stabilization");
  sp_add_time_a: assert property (cmd_fire && cmd.op == OPCODE_OP // RULE16
    && cmd.opcode == SP_IMM_ADD_OPCODE |=> !cmd_ready ##1
    (result.done && stack_pointer == $past(stack_pointer, 2)
     + sext8($past(cmd.b, 2))))
    else $error("stack pointer immediate add wrong");
  branch_time_a: assert property (cmd_fire && cmd.op == OPCODE_OP // RULE18
    && cmd.opcode == NO_CARRY_BRANCH_OPCODE |=> !cmd_ready[*2] ##1
    (result.done && result.taken == !$past(flags[C_BIT])))
    else $error("carry-clear branch timing or decision wrong");

  irq_taken_c: cover property (take_irq ##6 vector_fetch);
  wait_exit_c: cover property (cpu_clock_off ##1 !cpu_clock_off);
  branch_taken_c: cover property (result.done && result.taken);
  stop_done_c: cover property (s_q.st == ST_STABILIZE ##1 s_q.st == ST_RUN);

endmodule
`default_nettype wire

// [verif/cpu_condition_flags_unit_tb_top.sv]
// self-checking bench of the condition-flags unit
`timescale 1ns/1ps
`default_nettype none
module cpu_condition_flags_unit_tb_top import cpu_flags_pkg::*; ();
  typedef struct {
    logic [7:0] v, f, fm;
    logic t;
    logic [15:0] pc, sp, hx;
    int at;
    logic [2:0] w;
  } exp_t;
  localparam int STAB = 8;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic cmd_valid = 1'b0;
  cmd_t cmd = '0;
  logic cmd_ready, stack_push, vector_fetch, cpu_clock_off;
  res_t result;
  logic [7:0] irq_req = 8'h00;
  logic ext_irq = 1'b0;
  logic [2:0] stack_slot;
  logic [3:0] vector_id;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] flags, reg_rdata;
  logic [15:0] stack_pointer, index_reg;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rd_seen = 1'b0;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [7:0] ef = FLAGS_RESET;
  logic [15:0] esp = SP_RESET;
  logic [15:0] ehx = HX_RESET;
  exp_t cq[$];
  logic [7:0] rq[$];
  op_kind_t alu_ops [8] = '{ADD_OP, ADC_OP, SUB_OP, SBC_OP, LOGIC_AND_OP,
                           SHIFT_LEFT_OP, SHIFT_RIGHT_OP, ROTATE_LEFT_OP};
  logic [7:0] opc [3] = '{SP_IMM_ADD_OPCODE, IX_IMM_ADD_OPCODE,
                          NO_CARRY_BRANCH_OPCODE};

  always #2.5 clock = ~clock;

  cpu_condition_flags_unit #(.NUM_IRQ(8), .OSC_STAB_CYCLES(STAB)) u_dut (
    .clock(clock), .resetn(resetn), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .result(result), .irq_req(irq_req),
    .ext_irq(ext_irq), .stack_push(stack_push), .stack_slot(stack_slot),
    .vector_fetch(vector_fetch), .vector_id(vector_id),
    .cpu_clock_off(cpu_clock_off), .flags(flags),
    .stack_pointer(stack_pointer), .index_reg(index_reg),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] x,
                     input string what);
    cmp_count++;
    if (got !== x) begin
      err_total++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, x);
    end
  endtask

  task automatic wrap_up();
    if (err_total == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  function automatic cmd_t mk(input op_kind_t op, input logic [7:0] a,
                              input logic [7:0] b);
    mk = '0;
    mk.op = op;
    mk.a = a;
    mk.b = b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    // a bus write can raise the mask but never lower it
    if (a == FLAGS_OFS)
      ef = (d & 8'h97) | ONES_MASK | (ef & 8'h08) | (d & 8'h08);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] x);
    rq.push_back(x);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
  endtask

  // reference model and driver in one: the note is queued before the take
  task automatic issue(input cmd_t c);
    exp_t e;
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] fix;
    logic [15:0] rel;
    logic cin;
    e = '{8'h00, 8'h00, 8'hff, 1'b0, 16'h0000, 16'h0000, 16'h0000, 1, 3'b000};
    rel = {{8{c.b[7]}}, c.b};
    cin = (c.op == ADC_OP || c.op == SBC_OP || c.op == ROTATE_LEFT_OP)
          && ef[0];
    case (c.op)
      ADD_OP, ADC_OP: begin
        s = {1'b0, c.a} + {1'b0, c.b} + {8'h00, cin};
        h = {1'b0, c.a[3:0]} + {1'b0, c.b[3:0]} + {4'h0, cin};
        ef[4] = h[4];
        ef[7] = (c.a[7] == c.b[7]) && (s[7] != c.a[7]);
        ef[0] = s[8];
        e.v = s[7:0];
      end
      SUB_OP, SBC_OP: begin
        s = {1'b0, c.a} - {1'b0, c.b} - {8'h00, cin};
        ef[7] = (c.a[7] != c.b[7]) && (s[7] != c.a[7]);
        ef[0] = s[8];
        e.v = s[7:0];
      end
      LOGIC_AND_OP: begin
        e.v = c.a & c.b;
        ef[7] = 1'b0;
      end
      SHIFT_LEFT_OP, ROTATE_LEFT_OP: begin
        e.v = {c.a[6:0], cin};
        ef[0] = c.a[7];
        ef[7] = e.v[7] ^ c.a[7];
      end
      SHIFT_RIGHT_OP: begin
        e.v = {c.a[7], c.a[7:1]};
        ef[0] = c.a[0];
        ef[7] = e.v[7] ^ c.a[0];
      end
      DECIMAL_ADJUST_OP: begin
        fix = (ef[0] || c.a > BCD_MAX) ? DAA_HIGH_FIX : 8'h00;
        fix = fix | ((ef[4] || c.a[3:0] > NIBBLE_MAX) ? DAA_LOW_FIX : 8'h00);
        e.v = c.a + fix;
        ef[0] = fix[5];
        e.fm = 8'hef;
      end
      CLEAR_MASK_OP, WAIT_OP, STOP_OP: ef[3] = 1'b0;
      SET_MASK_OP: ef[3] = 1'b1;
      RETURN_FROM_INTERRUPT_OP: begin
        ef = c.stacked_flags | ONES_MASK;
        esp = esp + PUSH_BYTES;
      end
      SIGNED_BRANCH_OP: begin
        case (c.cond)
          BRANCH_SIGNED_GREATER_OP: e.t = !(ef[1] | (ef[2] ^ ef[7]));
          BRANCH_SIGNED_GREATER_EQUAL_OP: e.t = !(ef[2] ^ ef[7]);
          BRANCH_SIGNED_LESS_EQUAL_OP: e.t = ef[1] | (ef[2] ^ ef[7]);
          default: e.t = ef[2] ^ ef[7];
        endcase
        e.pc = c.pc + BRANCH_PC_STEP + (e.t ? rel : 16'h0000);
        e.w = 3'b110;
      end
      BIT_TEST_BRANCH_OP: begin
        ef[0] = c.a[c.b[2:0]];
        e.t = ef[0];
        e.fm = 8'h01;
        e.w = 3'b010;
      end
      default: begin
        e.at = 2;
        if (c.opcode == SP_IMM_ADD_OPCODE) esp = esp + rel;
        else if (c.opcode == IX_IMM_ADD_OPCODE) ehx = ehx + rel;
        else begin
          e.t = !ef[0];
          e.pc = c.pc + BRANCH_PC_STEP + (e.t ? rel : 16'h0000);
          e.at = 3;
          e.w = 3'b110;
        end
      end
    endcase
    if (c.op >= ADD_OP && c.op <= DECIMAL_ADJUST_OP) begin
      e.w = 3'b001;
      ef[2] = e.v[7];
      ef[1] = (e.v == 8'h00);
    end
    e.f = ef;
    e.sp = esp;
    e.hx = ehx;
    @(posedge clock);
    cmd <= c;
    cmd_valid <= 1'b1;
    @(negedge clock);
    for (int i = 0; i < 50 && cmd_ready !== 1'b1; i++) @(negedge clock);
    e.at = e.at + cyc;
    cq.push_back(e);
    @(posedge clock);
    cmd_valid <= 1'b0;
  endtask

  task automatic irq_entry(input logic [3:0] id);
    int n;
    n = 0;
    for (int i = 0; i < 20 && vector_fetch !== 1'b1; i++) begin
      @(negedge clock);
      if (stack_push === 1'b1) begin
        chk(16'(stack_slot), 16'(n), "stack slot");
        chk(16'(flags[3]), 16'h0, "mask while stacking");
        n++;
      end
    end
    esp = esp - PUSH_BYTES;
    ef[3] = 1'b1;
    chk(16'(n), 16'h5, "bytes stacked");
    chk(16'(vector_fetch), 16'h1, "vector fetch");
    chk(16'(flags), 16'(ef), "mask at vector");
    chk(16'(vector_id), 16'(id), "served request");
    chk(stack_pointer, esp, "sp after entry");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clock) rd_seen <= reg_rd;

  always @(negedge clock) begin : watch
    exp_t e;
    cyc <= cyc + 1;
    if (rd_seen) chk(16'(reg_rdata), 16'(rq.pop_front()), "read");
    if (result.done === 1'b1 && cq.size() == 0)
      chk(16'h1, 16'h0, "extra done");
    else if (result.done === 1'b1) begin
      e = cq.pop_front();
      chk(16'(cyc), 16'(e.at), "latency");
      chk(16'(flags & e.fm), 16'(e.f & e.fm), "flags");
      chk(stack_pointer, e.sp, "stack pointer");
      chk(index_reg, e.hx, "index");
      if (e.w[0]) chk(16'(result.value), 16'(e.v), "value");
      if (e.w[1]) chk(16'(result.taken), 16'(e.t), "taken");
      if (e.w[2]) chk(result.pc_next, e.pc, "next pc");
    end
  end

  initial begin : dog
    #100000;
    err_total++;
    wrap_up();
  end

  initial begin : main
    cmd_t c;
    int n;
    void'($urandom(32'h5844));
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    rd(FLAGS_OFS, FLAGS_RESET);
    wr(FLAGS_OFS, 8'h00);
    rd(FLAGS_OFS, ef);
    wr(FLAGS_OFS, 8'hff);
    rd(FLAGS_OFS, 8'hff);
    rd(4'h7, 8'h00);
    issue(mk(ADD_OP, 8'h7f, 8'h01));
    issue(mk(ADD_OP, 8'hff, 8'h01));
    for (int i = 0; i < 48; i++)
      issue(mk(alu_ops[i % 8], 8'($urandom), 8'($urandom)));
    issue(mk(ADD_OP, 8'h38, 8'h49));
    issue(mk(DECIMAL_ADJUST_OP, 8'h81, 8'h00));
    issue(mk(ADD_OP, 8'h99, 8'h99));
    issue(mk(DECIMAL_ADJUST_OP, 8'h32, 8'h00));
    for (int i = 0; i < 8; i++)
      issue(mk(BIT_TEST_BRANCH_OP, 8'ha5, 8'(i)));
    // each flag write resyncs the model bits left open by the ops above
    for (int i = 0; i < 16; i++) begin
      wr(FLAGS_OFS, 8'($urandom) & 8'h86);
      c = mk(SIGNED_BRANCH_OP, 8'h00, 8'h10);
      c.cond = branch_cond_t'(i % 4);
      issue(c);
    end
    for (int i = 0; i < 6; i++) begin
      // let a running branch finish before its flags change under it
      repeat (2) @(posedge clock);
      wr(FLAGS_OFS, 8'(i));
      c = mk(OPCODE_OP, 8'h00, 8'($urandom));
      c.opcode = opc[i % 3];
      c.pc = 16'($urandom);
      issue(c);
    end
    @(posedge clock);
    irq_req <= 8'h28;
    repeat (10) begin
      @(negedge clock);
      chk(16'(stack_push), 16'h0, "masked request taken");
    end
    issue(mk(CLEAR_MASK_OP, 8'h00, 8'h00));
    irq_entry(4'h3);
    @(posedge clock);
    irq_req <= 8'h00;
    c = mk(RETURN_FROM_INTERRUPT_OP, 8'h00, 8'h00);
    c.stacked_flags = 8'h09;
    issue(c);
    issue(mk(WAIT_OP, 8'h00, 8'h00));
    repeat (4) @(negedge clock);
    chk(16'(cpu_clock_off), 16'h1, "wait clock off");
    chk(16'(cmd_ready), 16'h0, "ready in wait");
    rd(STATUS_OFS, 8'h33);
    @(posedge clock);
    irq_req <= 8'h80;
    irq_entry(4'h7);
    @(posedge clock);
    irq_req <= 8'h00;
    issue(mk(STOP_OP, 8'h00, 8'h00));
    repeat (3) @(negedge clock);
    chk(16'(cpu_clock_off), 16'h1, "stop clock off");
    @(posedge clock);
    ext_irq <= 1'b1;
    n = 0;
    for (int i = 0; i < 40 && cpu_clock_off !== 1'b0; i++) begin
      @(negedge clock);
      n++;
    end
    @(posedge clock);
    ext_irq <= 1'b0;
    // stabilization length plus a cycle or two of entry and exit
    chk(16'(n >= STAB && n <= STAB + 3), 16'h1, "stabilization");
    chk(16'(flags[3]), 16'h0, "mask after stop exit");
    issue(mk(WAIT_OP, 8'h00, 8'h00));
    repeat (3) @(posedge clock);
    resetn <= 1'b0;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    ef = FLAGS_RESET;
    esp = SP_RESET;
    ehx = HX_RESET;
    @(negedge clock);
    chk(16'(flags), 16'(FLAGS_RESET), "mask after reset exit");
    chk(16'(cpu_clock_off), 16'h0, "clock after reset");
    issue(mk(SUB_OP, 8'h10, 8'h20));
    repeat (5) @(posedge clock);
    chk(16'(cq.size() + rq.size()), 16'h0, "results missing");
    wrap_up();
  end
endmodule
`default_nettype wire
